// file: hw/sysctl_defs.vh
// register offsets, field positions, reset values and timing counts of the system-control bank
`ifndef SYSCTL_DEFS_VH
`define SYSCTL_DEFS_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define ADDR_CLKOUT_SEL      32'h400480E0
`define ADDR_CLKOUT_UPDATE   32'h400480E4
`define ADDR_CLKOUT_DIV      32'h400480E8
`define ADDR_CAPTURE_LOW     32'h40048100
`define ADDR_CAPTURE_HIGH    32'h40048104
`define ADDR_BROWNOUT_CTRL   32'h40048150
`define ADDR_TICK_CAL        32'h40048154
`define ADDR_WAKE_EDGE       32'h40048200
`define ADDR_EVENT_STATUS    32'h40048300
`define ADDR_EVENT_MASK      32'h40048304

// ----------------------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------------------
`define UPDATE_STROBE_BIT    0
`define SRC_SEL_W            2
`define DIV_W                8
`define BOD_RST_LSB          0
`define BOD_INT_LSB          2
`define BOD_RST_EN_BIT       4
`define TICK_CAL_W           26
`define WAKE_W               13
`define CAP_HIGH_W           10
`define EVENT_W              3
`define EV_BOD_INT           0
`define EV_BOD_RST           1
`define EV_SRC_APPLIED       2

// ----------------------------------------------------------------------------
// clock-output source codes
// ----------------------------------------------------------------------------
`define SRC_INTERNAL_RC      2'h0
`define SRC_SYSTEM_OSC       2'h1
`define SRC_WATCHDOG_OSC     2'h2
`define SRC_MAIN_CLOCK       2'h3

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define RST_SRC_SEL          2'h0
`define RST_UPDATE           1'h0
`define RST_DIV              8'h00
`define RST_BOD_CTRL         5'h00
`define RST_TICK_CAL         26'h0000004
`define RST_WAKE_EDGE        13'h0000
`define CAPTURE_DELAY        3'h4

`endif

// file: hw/pin_sync.v
// three-stage synchroniser with agreement filter for asynchronous pins
`default_nettype none

module pin_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             clk_sys,
    input  wire             rst_n,
    // pins and filtered levels
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] level_out
);

    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;
    reg [WIDTH-1:0] stage3_reg;

    genvar i;

    // ------------------------------------------------------------------------
    // stages
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
            stage3_reg <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // a change counts only once stages two and three agree
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_agree
            always @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                    level_out[i] <= 1'b0;
                else if (stage2_reg[i] == stage3_reg[i])
                    level_out[i] <= stage3_reg[i];
            end
        end
    endgenerate

endmodule

`default_nettype wire

// file: hw/sysctl_regs.v
// system-control register bank: clock output, pin capture, brown-out, tick cal, wake edges
//
// Function
// - update bit 0, reset zero, requests source
// - source codes: rc, system, watchdog, main
// - divider 7:0; zero off, N divides
// - low capture latches pin levels at power-on
// - low capture layout: port0, port1, port2
// - high capture: port2 8-11, port3 0-5
// - high capture read-only, power-on pin levels
// - reset level field 1:0, four thresholds
// - interrupt level field 3:2, four thresholds
// - interrupt on crossing; reset when enabled
// - tick calibration 25:0, reset 0x04
// - edge select for port0 0-11, port1 0
// - zero falling, one rising, reset zero
// - bit n drives wake interrupt n, 13
`include "sysctl_defs.vh"
`default_nettype none

module sysctl_regs #(
    parameter ADDR_W = 32,
    parameter DATA_W = 32
) (
    // clock and power-on reset
    input  wire              clk_sys,
    input  wire              rst_n,
    // register port
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire [DATA_W-1:0] reg_wdata,
    input  wire              reg_write,
    input  wire              reg_read,
    output reg  [DATA_W-1:0] reg_rdata,
    // pins sampled at power-on
    input  wire [11:0]       port0_pins,
    input  wire [11:0]       port1_pins,
    input  wire [11:0]       port2_pins,
    input  wire [5:0]        port3_pins,
    // brown-out comparators, one per level, high when supply below it
    input  wire [3:0]        bod_reset_below,
    input  wire [3:0]        bod_int_below,
    // clock-output control to the clock generator
    output reg  [1:0]        clock_output_source_select,
    output reg  [7:0]        clock_output_divider,
    output reg               clock_output_enable,
    // brown-out outputs
    output reg  [1:0]        brownout_reset_level,
    output reg  [1:0]        brownout_interrupt_level,
    output reg               brownout_irq,
    output reg               brownout_chip_reset,
    // tick timer calibration
    output reg  [25:0]       tick_timer_calibration_readback,
    // wake-up interrupts
    output reg  [12:0]       wake_irq,
    // bank interrupt
    output reg               irq
);

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg  [1:0]             source_select_reg;
    reg                    clock_output_update_strobe_reg;
    reg  [7:0]             divider_reg;
    reg  [4:0]             brownout_control_reg;
    reg  [25:0]            tick_calibration_reg;
    reg  [12:0]            wake_edge_select_reg;
    reg  [`EVENT_W-1:0]    event_status_reg;
    reg  [`EVENT_W-1:0]    event_mask_reg;
    reg  [31:0]            power_on_pin_capture_low_reg;
    reg  [9:0]             power_on_pin_capture_high_reg;
    reg                    capture_done_reg;
    reg  [2:0]             capture_wait_reg;
    reg  [12:0]            wake_prev_reg;
    reg                    bod_int_prev_reg;
    reg                    bod_rst_prev_reg;
    reg  [1:0]             active_source_reg;
    reg  [DATA_W-1:0]      read_next;
    reg  [`EVENT_W-1:0]    event_status_next;

    wire [41:0]            pins_level;
    wire [3:0]             bod_reset_level_sync;
    wire [3:0]             bod_int_level_sync;
    wire [12:0]            wake_level;
    wire                   bod_int_now;
    wire                   bod_rst_now;
    wire [12:0]            wake_event;
    wire                   source_applied;
    wire [`EVENT_W-1:0]    event_set;

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    function hit;
        input [ADDR_W-1:0] addr;
        input [31:0]       target;
        begin
            hit = (addr == target[ADDR_W-1:0]);
        end
    endfunction

    // ------------------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------------------
    pin_sync #(
        .WIDTH (42)
    ) u_pins_sync (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .pin_in    ({port3_pins, port2_pins, port1_pins, port0_pins}),
        .level_out (pins_level)
    );

    pin_sync #(
        .WIDTH (8)
    ) u_bod_sync (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .pin_in    ({bod_reset_below, bod_int_below}),
        .level_out ({bod_reset_level_sync, bod_int_level_sync})
    );

    // wake pins reuse the synchronised port levels: port0 0-11 and port1 0
    assign wake_level = {pins_level[12], pins_level[11:0]};

    // ------------------------------------------------------------------------
    // power-on pin capture
    // ------------------------------------------------------------------------
    // waits for the synchroniser to settle, then loads once; only rst_n rearms it
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            capture_wait_reg              <= 3'h0;
            capture_done_reg              <= 1'b0;
            power_on_pin_capture_low_reg  <= 32'h00000000;
            power_on_pin_capture_high_reg <= 10'h000;
        end
        else if (!capture_done_reg)
        begin
            if (capture_wait_reg == `CAPTURE_DELAY)
            begin
                capture_done_reg <= 1'b1;
                // port0 11:0, port1 11:0, port2 7:0
                power_on_pin_capture_low_reg <= pins_level[31:0];
                // port2 8-11 then port3 0-5
                power_on_pin_capture_high_reg <= pins_level[41:32];
            end
            else
            begin
                capture_wait_reg <= capture_wait_reg + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // software-written registers
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            source_select_reg              <= `RST_SRC_SEL;
            clock_output_update_strobe_reg <= `RST_UPDATE;
            divider_reg                    <= `RST_DIV;
            brownout_control_reg           <= `RST_BOD_CTRL;
            tick_calibration_reg           <= `RST_TICK_CAL;
            wake_edge_select_reg           <= `RST_WAKE_EDGE;
            event_mask_reg                 <= {`EVENT_W{1'b0}};
        end
        else if (reg_write)
        begin
            if (hit(reg_addr, `ADDR_CLKOUT_SEL))
                source_select_reg <= reg_wdata[`SRC_SEL_W-1:0];
            if (hit(reg_addr, `ADDR_CLKOUT_UPDATE))
                clock_output_update_strobe_reg <= reg_wdata[`UPDATE_STROBE_BIT];
            if (hit(reg_addr, `ADDR_CLKOUT_DIV))
                divider_reg <= reg_wdata[`DIV_W-1:0];
            if (hit(reg_addr, `ADDR_BROWNOUT_CTRL))
                brownout_control_reg <= reg_wdata[4:0];
            if (hit(reg_addr, `ADDR_TICK_CAL))
                tick_calibration_reg <= reg_wdata[`TICK_CAL_W-1:0];
            if (hit(reg_addr, `ADDR_WAKE_EDGE))
                wake_edge_select_reg <= reg_wdata[`WAKE_W-1:0];
            if (hit(reg_addr, `ADDR_EVENT_MASK))
                event_mask_reg <= reg_wdata[`EVENT_W-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // clock-output source switch
    // ------------------------------------------------------------------------
    // only a 0-to-1 write of the update bit moves the selection across
    assign source_applied = reg_write && hit(reg_addr, `ADDR_CLKOUT_UPDATE)
                            && reg_wdata[`UPDATE_STROBE_BIT]
                            && !clock_output_update_strobe_reg;

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            active_source_reg <= `SRC_INTERNAL_RC;
        else if (source_applied)
            active_source_reg <= source_select_reg;
    end

    // ------------------------------------------------------------------------
    // brown-out detection
    // ------------------------------------------------------------------------
    assign bod_int_now = bod_int_level_sync[brownout_control_reg[3:2]];
    assign bod_rst_now = bod_reset_level_sync[brownout_control_reg[1:0]];

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bod_int_prev_reg <= 1'b0;
            bod_rst_prev_reg <= 1'b0;
        end
        else
        begin
            bod_int_prev_reg <= bod_int_now;
            bod_rst_prev_reg <= bod_rst_now;
        end
    end

    // ------------------------------------------------------------------------
    // wake-up edge detection
    // ------------------------------------------------------------------------
    genvar w;
    generate
        for (w = 0; w < `WAKE_W; w = w + 1)
        begin : g_wake
            // 1 picks a rising edge, 0 a falling one
            assign wake_event[w] = wake_edge_select_reg[w]
                                   ? (wake_level[w] && !wake_prev_reg[w])
                                   : (!wake_level[w] && wake_prev_reg[w]);
        end
    endgenerate

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            wake_prev_reg <= 13'h0000;
        else
            wake_prev_reg <= wake_level;
    end

    // ------------------------------------------------------------------------
    // event status, write one to clear, set wins
    // ------------------------------------------------------------------------
    assign event_set = {source_applied,
                        bod_rst_now && !bod_rst_prev_reg,
                        bod_int_now && !bod_int_prev_reg};

    always @*
    begin
        event_status_next = event_status_reg;
        if (reg_write && hit(reg_addr, `ADDR_EVENT_STATUS))
            event_status_next = event_status_next & ~reg_wdata[`EVENT_W-1:0];
        event_status_next = event_status_next | event_set;
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            event_status_reg <= {`EVENT_W{1'b0}};
        else
            event_status_reg <= event_status_next;
    end

    // ------------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------------
    always @*
    begin
        read_next = {DATA_W{1'b0}};
        if (hit(reg_addr, `ADDR_CLKOUT_SEL))
            read_next[1:0] = source_select_reg;
        else if (hit(reg_addr, `ADDR_CLKOUT_UPDATE))
            read_next[0] = clock_output_update_strobe_reg;
        else if (hit(reg_addr, `ADDR_CLKOUT_DIV))
            read_next[7:0] = divider_reg;
        else if (hit(reg_addr, `ADDR_CAPTURE_LOW))
            read_next[31:0] = power_on_pin_capture_low_reg;
        else if (hit(reg_addr, `ADDR_CAPTURE_HIGH))
            read_next[9:0] = power_on_pin_capture_high_reg;
        else if (hit(reg_addr, `ADDR_BROWNOUT_CTRL))
            read_next[4:0] = brownout_control_reg;
        else if (hit(reg_addr, `ADDR_TICK_CAL))
            read_next[25:0] = tick_calibration_reg;
        else if (hit(reg_addr, `ADDR_WAKE_EDGE))
            read_next[12:0] = wake_edge_select_reg;
        else if (hit(reg_addr, `ADDR_EVENT_STATUS))
            read_next[`EVENT_W-1:0] = event_status_reg;
        else if (hit(reg_addr, `ADDR_EVENT_MASK))
            read_next[`EVENT_W-1:0] = event_mask_reg;
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= {DATA_W{1'b0}};
        else if (reg_read)
            reg_rdata <= read_next;
        else
            reg_rdata <= {DATA_W{1'b0}};
    end

    // ------------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clock_output_source_select      <= `SRC_INTERNAL_RC;
            clock_output_divider            <= `RST_DIV;
            clock_output_enable             <= 1'b0;
            brownout_reset_level            <= 2'h0;
            brownout_interrupt_level        <= 2'h0;
            brownout_irq                    <= 1'b0;
            brownout_chip_reset             <= 1'b0;
            tick_timer_calibration_readback <= `RST_TICK_CAL;
            wake_irq                        <= 13'h0000;
            irq                             <= 1'b0;
        end
        else
        begin
            clock_output_source_select      <= active_source_reg;
            clock_output_divider            <= divider_reg;
            clock_output_enable             <= (divider_reg != 8'h00);
            brownout_reset_level            <= brownout_control_reg[1:0];
            brownout_interrupt_level        <= brownout_control_reg[3:2];
            brownout_irq                    <= bod_int_now;
            // reset forced only while enabled and below the reset level
            brownout_chip_reset             <= bod_rst_now
                                               && brownout_control_reg[`BOD_RST_EN_BIT];
            tick_timer_calibration_readback <= tick_calibration_reg;
            wake_irq                        <= wake_event;
            irq                             <= |(event_status_next & event_mask_reg);
        end
    end

endmodule

`default_nettype wire

// file: testbench/sysctl_regs_assertions.sv
// concurrent checks on the system-control bank ports
`default_nettype none
`include "sysctl_defs.vh"

module sysctl_regs_assertions #(
    parameter ADDR_W = 32,
    parameter DATA_W = 32
) (
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              rst_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_write,
    input wire logic              reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    // watched outputs
    input wire logic [1:0]        clock_output_source_select,
    input wire logic [7:0]        clock_output_divider,
    input wire logic              clock_output_enable,
    input wire logic [1:0]        brownout_reset_level,
    input wire logic [1:0]        brownout_interrupt_level,
    input wire logic [25:0]       tick_timer_calibration_readback,
    input wire logic [12:0]       wake_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // write decodes
    // ------------------------------------------------------------------
    wire w_div  = reg_write && reg_addr == `ADDR_CLKOUT_DIV;
    wire w_upd  = reg_write && reg_addr == `ADDR_CLKOUT_UPDATE;
    wire w_bod  = reg_write && reg_addr == `ADDR_BROWNOUT_CTRL;
    wire w_tick = reg_write && reg_addr == `ADDR_TICK_CAL;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // only a zero then a one applies a source
    sequence s_zero_then_one;
        (w_upd && !reg_wdata[0]) ##2 (w_upd && reg_wdata[0]);
    endsequence

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    chk_div_enable: assert property (
        clock_output_enable == (clock_output_divider != 8'h00))
        else $error("divider enable disagrees with divider");
    chk_div_value: assert property (
        w_div |-> ##2 clock_output_divider == $past(reg_wdata[7:0], 2))
        else $error("divider output not the written value");
    chk_src_apply: assert property (
        $changed(clock_output_source_select) |->
        $past(w_upd && reg_wdata[0], 2) || $past(w_upd && reg_wdata[0], 3))
        else $error("source changed without an update write");
    chk_rst_level: assert property (
        w_bod |-> ##2 brownout_reset_level == $past(reg_wdata[1:0], 2))
        else $error("reset level not the written field");
    chk_int_level: assert property (
        w_bod |-> ##2 brownout_interrupt_level == $past(reg_wdata[3:2], 2))
        else $error("interrupt level not the written field");
    chk_tick_reset: assert property (
        $rose(rst_n) |-> tick_timer_calibration_readback == 26'h0000004)
        else $error("tick calibration reset value wrong");
    chk_tick_value: assert property (
        w_tick |-> ##2 tick_timer_calibration_readback == $past(reg_wdata[25:0], 2))
        else $error("tick calibration not the written value");
    chk_wake_pulse: assert property (
        wake_irq != 13'h0000 |=> (wake_irq & $past(wake_irq)) == 13'h0000)
        else $error("wake interrupt longer than one cycle");
    chk_cap_reserved: assert property (
        reg_read && reg_addr == `ADDR_CAPTURE_HIGH |=> reg_rdata[31:10] == 22'h0)
        else $error("reserved capture bits not zero");
    cov_switch: cover property (s_zero_then_one);
endmodule
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the system-control register bank
`default_nettype none
`include "sysctl_defs.vh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic        clk_sys = 1'h0;
    logic        rst_n = 1'h0;
    logic [31:0] reg_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'h0;
    logic        reg_read = 1'h0;
    logic [11:0] port0_pins = 12'hA5B;
    logic [11:0] port1_pins = 12'h3C6;
    logic [11:0] port2_pins = 12'h9E1;
    logic [5:0]  port3_pins = 6'h2D;
    logic [3:0]  bod_reset_below = 4'h0;
    logic [3:0]  bod_int_below = 4'h0;
    wire  [31:0] reg_rdata;
    wire  [1:0]  clock_output_source_select;
    wire  [7:0]  clock_output_divider;
    wire         clock_output_enable;
    wire  [1:0]  brownout_reset_level;
    wire  [1:0]  brownout_interrupt_level;
    wire         brownout_irq;
    wire         brownout_chip_reset;
    wire  [25:0] tick_timer_calibration_readback;
    wire  [12:0] wake_irq;
    wire         irq;
    int          n_fail = 0;
    int          n_compared = 0;
    int          cycles = 0;
    logic [7:0]  divs [4] = '{8'h01, 8'hFF, 8'h80, 8'h00};

    sysctl_regs u_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .port0_pins, .port1_pins, .port2_pins, .port3_pins, .bod_reset_below,
        .bod_int_below, .clock_output_source_select, .clock_output_divider,
        .clock_output_enable, .brownout_reset_level, .brownout_interrupt_level,
        .brownout_irq, .brownout_chip_reset, .tick_timer_calibration_readback,
        .wake_irq, .irq);

    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic summarize;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clk_sys);
        reg_write <= 1'h0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clk_sys);
        reg_read <= 1'h0;
        #1;
        cmp(reg_rdata, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // window spans the synchroniser delay
    task automatic wake(input int b, input logic [31:0] exp);
        logic [31:0] seen;
        seen = 32'h0;
        repeat (12)
        begin
            @(posedge clk_sys);
            #1;
            if (wake_irq[b] === 1'h1) seen = 32'h1;
        end
        cmp(seen, exp);
    endtask

    // hang guard, far above run length
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_fail++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'h1;
        settle(1);
        cmp({6'h0, tick_timer_calibration_readback}, 32'h4);
        rd(`ADDR_CLKOUT_UPDATE, 32'h0);
        rd(`ADDR_CLKOUT_DIV, 32'h0);
        rd(`ADDR_BROWNOUT_CTRL, 32'h0);
        rd(`ADDR_TICK_CAL, 32'h4);
        rd(`ADDR_WAKE_EDGE, 32'h0);
        settle(16);
        rd(`ADDR_CAPTURE_LOW, 32'hE13C6A5B);
        rd(`ADDR_CAPTURE_HIGH, 32'h2D9);
        wr(`ADDR_CAPTURE_LOW, 32'h0);
        wr(`ADDR_CAPTURE_HIGH, 32'hFFFFFFFF);
        rd(`ADDR_CAPTURE_LOW, 32'hE13C6A5B);
        rd(`ADDR_CAPTURE_HIGH, 32'h2D9);
        wr(32'h40048108, 32'hFFFFFFFF);
        rd(32'h40048108, 32'h0);
        foreach (divs[i])
        begin
            wr(`ADDR_CLKOUT_DIV, 32'hFFFFFF00 | {24'h0, divs[i]});
            settle(2);
            cmp({24'h0, clock_output_divider}, {24'h0, divs[i]});
            cmp({31'h0, clock_output_enable}, {31'h0, divs[i] != 8'h00});
            rd(`ADDR_CLKOUT_DIV, {24'h0, divs[i]});
        end
        for (int c = 1; c < 5; c++)
        begin
            wr(`ADDR_CLKOUT_SEL, 32'(c % 4));
            wr(`ADDR_CLKOUT_UPDATE, 32'h0);
            wr(`ADDR_CLKOUT_UPDATE, 32'h1);
            settle(3);
            cmp({30'h0, clock_output_source_select}, 32'(c % 4));
        end
        rd(`ADDR_CLKOUT_UPDATE, 32'h1);
        wr(`ADDR_CLKOUT_SEL, 32'h2);
        wr(`ADDR_CLKOUT_UPDATE, 32'h1);
        settle(3);
        cmp({30'h0, clock_output_source_select}, 32'h0);
        // source-applied event via status, mask and irq
        rd(`ADDR_EVENT_STATUS, 32'h4);
        cmp({31'h0, irq}, 32'h0);
        wr(`ADDR_EVENT_MASK, 32'h4);
        settle(1);
        cmp({31'h0, irq}, 32'h1);
        wr(`ADDR_EVENT_STATUS, 32'h4);
        rd(`ADDR_EVENT_STATUS, 32'h0);
        cmp({31'h0, irq}, 32'h0);
        for (int c = 0; c < 4; c++)
        begin
            wr(`ADDR_BROWNOUT_CTRL, 32'(c * 5));
            settle(2);
            cmp({28'h0, brownout_interrupt_level, brownout_reset_level}, 32'(c*5));
        end
        wr(`ADDR_BROWNOUT_CTRL, 32'h09);
        @(posedge clk_sys);
        bod_int_below   <= 4'h4;
        bod_reset_below <= 4'h2;
        settle(12);
        cmp({31'h0, brownout_irq}, 32'h1);
        cmp({31'h0, brownout_chip_reset}, 32'h0);
        rd(`ADDR_EVENT_STATUS, 32'h3);
        wr(`ADDR_BROWNOUT_CTRL, 32'h19);
        settle(2);
        cmp({31'h0, brownout_chip_reset}, 32'h1);
        @(posedge clk_sys);
        bod_int_below   <= 4'hB;
        bod_reset_below <= 4'hD;
        settle(12);
        cmp({30'h0, brownout_irq, brownout_chip_reset}, 32'h0);
        wr(`ADDR_TICK_CAL, 32'hFFFFFFFF);
        settle(2);
        cmp({6'h0, tick_timer_calibration_readback}, 32'h03FFFFFF);
        rd(`ADDR_TICK_CAL, 32'h03FFFFFF);
        wr(`ADDR_WAKE_EDGE, 32'hFFFF1000);
        rd(`ADDR_WAKE_EDGE, 32'h1000);
        @(posedge clk_sys);
        port0_pins[3] <= 1'h0;
        wake(3, 32'h1);
        port0_pins[2] <= 1'h1;
        wake(2, 32'h0);
        port1_pins[0] <= 1'h1;
        wake(12, 32'h1);
        port1_pins[0] <= 1'h0;
        wake(12, 32'h0);
        rd(`ADDR_CAPTURE_LOW, 32'hE13C6A5B);
        // a second power-on reset takes a fresh capture
        @(posedge clk_sys);
        rst_n <= 1'h0;
        @(posedge clk_sys);
        rst_n <= 1'h1;
        settle(20);
        rd(`ADDR_CAPTURE_LOW, 32'hE13C6A57);
        rd(`ADDR_TICK_CAL, 32'h4);
        summarize();
    end
endmodule

bind sysctl_regs sysctl_regs_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .clock_output_source_select, .clock_output_divider, .clock_output_enable,
    .brownout_reset_level, .brownout_interrupt_level, .tick_timer_calibration_readback,
    .wake_irq);
`default_nettype wire
